// file: dv/iex_core_tb_top.sv
module iex_core_tb_top
   import iex_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic instr_valid = 1'b0;
   iex_instr_s instr = '0;
   iex_bus_s bus = '0;
   logic instr_ready;
   logic [DATA_W-1:0] rdata;
   logic [PC_W-1:0] pc;
   logic [PC_W-1:0] top_of_stack;
   iex_status_s status;
   int n_errors = 0;
   int num_checks = 0;
   logic [DATA_W-1:0] m_acc;
   logic [DATA_W-1:0] m_f [NFREG];
   logic [LATCH_W-1:0] m_latch;
   logic [PC_W-1:0] m_pc;
   logic [PC_W-1:0] m_stack;
   logic m_z;
   logic m_skip;
   logic [DATA_W-1:0] d;
   logic [FIDX_W-1:0] fx;
   iex_instr_s ti;

   always #10 clk = ~clk;

   iex_core iex_core_inst (
      .clk(clk),
      .rst_n(rst_n),
      .instr_valid(instr_valid),
      .instr(instr),
      .instr_ready(instr_ready),
      .bus(bus),
      .rdata(rdata),
      .pc(pc),
      .top_of_stack(top_of_stack),
      .status(status)
   );

   // ************************************************
   // Reference model and bus tasks
   // ************************************************
   function automatic logic [DATA_W-1:0] alu(input iex_op_e op, input logic [DATA_W-1:0] f);
      return (op == OP_INVERT_FILE_REG) ? ~f : f - 8'h01;
   endfunction

   function automatic logic [15:0] exp_st();
      return 16'({m_z, 1'b1, 1'b1});
   endfunction

   function automatic logic [15:0] exp_sreg();
      return (16'(m_z) << STAT_ZERO) | (16'h0001 << STAT_EXPIRED_N)
         | (16'h0001 << STAT_SLEEP_N);
   endfunction

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic mdl(input iex_instr_s i);
      logic [DATA_W-1:0] r;
      r = alu(i.op, m_f[i.fidx]);
      if (m_skip) begin
         m_skip = 1'b0;
         m_pc = m_pc + 15'h0001;
      end else if (i.op == OP_CALL_VIA_ACCUMULATOR) begin
         m_stack = m_pc + 15'h0001;
         m_pc = {m_latch, m_acc};
      end else begin
         m_pc = m_pc + 15'h0001;
         if (i.op == OP_ZERO_FILE_REG) m_f[i.fidx] = 8'h00;
         if (i.op == OP_ZERO_ACCUMULATOR) m_acc = 8'h00;
         if (i.op inside {OP_ZERO_FILE_REG, OP_ZERO_ACCUMULATOR}) m_z = 1'b1;
         if (i.op inside {OP_INVERT_FILE_REG, OP_DECREMENT_FILE_REG,
                          OP_DECREMENT_SKIP_ON_NULL}) begin
            if (i.dest) m_f[i.fidx] = r;
            else m_acc = r;
         end
         if (i.op inside {OP_INVERT_FILE_REG, OP_DECREMENT_FILE_REG}) m_z = (r == 8'h00);
         if (i.op == OP_DECREMENT_SKIP_ON_NULL) m_skip = (r == 8'h00);
      end
   endtask

   task automatic bwr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] w);
      bus <= '{a, w, 1'b1, 1'b0};
      if (a < 8'h80) m_f[a[FIDX_W-1:0]] = w;
      if (a == A_ACC) m_acc = w;
      if (a == A_LATCH) m_latch = w[LATCH_W-1:0];
      @(posedge clk);
      bus <= '0;
      @(posedge clk);
   endtask

   task automatic brd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      bus <= '0;
      #1 v = rdata;
      @(posedge clk);
   endtask

   // Holds the offer through the dead cycle that follows a call
   task automatic exec(input iex_instr_s i);
      instr_valid <= 1'b1;
      instr <= i;
      do @(posedge clk); while (instr_ready !== 1'b1);
      mdl(i);
      instr_valid <= 1'b0;
      #1;
      chk("pc", 16'(pc), 16'(m_pc));
      chk("stack top", 16'(top_of_stack), 16'(m_stack));
      chk("status", 16'(status), exp_st());
      @(posedge clk);
   endtask

   task automatic chk_regs(input logic [FIDX_W-1:0] f);
      brd(A_ACC, d);
      chk("acc", 16'(d), 16'(m_acc));
      brd({1'b0, f}, d);
      chk("freg", 16'(d), 16'(m_f[f]));
      brd(A_LATCH, d);
      chk("latch", 16'(d), 16'(m_latch));
      brd(A_PC_LO, d);
      chk("pc lo", 16'(d), 16'(m_pc[DATA_W-1:0]));
      brd(A_PC_HI, d);
      chk("pc hi", 16'(d), 16'(m_pc[PC_W-1:DATA_W]));
      brd(A_STACK_LO, d);
      chk("stack lo", 16'(d), 16'(m_stack[DATA_W-1:0]));
      brd(A_STACK_HI, d);
      chk("stack hi", 16'(d), 16'(m_stack[PC_W-1:DATA_W]));
   endtask

   task automatic results();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ************************************************
   // Tests
   // ************************************************
   initial begin
      #(20 * 50000);
      n_errors++;
      results();
   end

   initial begin
      void'($urandom(60337));
      m_acc = 8'h00;
      m_latch = 7'h00;
      m_pc = 15'h0000;
      m_stack = 15'h0000;
      m_z = 1'b0;
      m_skip = 1'b0;
      foreach (m_f[k]) m_f[k] = 8'h00;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("reset pc", 16'(pc), 16'h0000);
      chk("reset status", 16'(status), exp_st());
      bwr(8'h90, 8'hA5);
      brd(8'h90, d);
      chk("unmapped", 16'(d), 16'h0000);
      // Call to the top of code space, then wrap of pc on the next step
      exec('{OP_NOP, 7'h00, 1'b0});
      bwr(A_LATCH, 8'h7F);
      bwr(A_ACC, 8'hFF);
      instr_valid <= 1'b1;
      instr <= '{OP_CALL_VIA_ACCUMULATOR, 7'h00, 1'b0};
      @(posedge clk);
      mdl('{OP_CALL_VIA_ACCUMULATOR, 7'h00, 1'b0});
      instr <= '{OP_ZERO_ACCUMULATOR, 7'h00, 1'b0};
      #1 chk("ready", 16'(instr_ready), 16'h0000);
      chk("call pc", 16'(pc), 16'h7FFF);
      chk("call stack top", 16'(top_of_stack), 16'(m_stack));
      @(posedge clk);
      #1 chk("stall pc", 16'(pc), 16'h7FFF);
      @(posedge clk);
      mdl('{OP_ZERO_ACCUMULATOR, 7'h00, 1'b0});
      instr_valid <= 1'b0;
      #1 chk("wrap pc", 16'(pc), 16'h0000);
      chk("zero flag", 16'(status), exp_st());
      @(posedge clk);
      chk_regs(7'h00);
      bwr(8'h7F, 8'h55);
      exec('{OP_ZERO_FILE_REG, 7'h7F, 1'b0});
      chk_regs(7'h7F);
      // Result 0 discards the clear that follows; result 1 lets it run
      for (int v = 1; v <= 2; v++) begin
         bwr(8'h03, 8'(v));
         bwr(A_ACC, 8'h5A);
         exec('{OP_DECREMENT_SKIP_ON_NULL, 7'h03, 1'(2 - v)});
         exec('{OP_ZERO_ACCUMULATOR, 7'h00, 1'b0});
         chk_regs(7'h03);
      end
      repeat (300) @(posedge clk);
      exec('{OP_KICK_WATCHDOG, 7'h00, 1'b0});
      brd(A_PRE, d);
      chk("prescaler", 16'(d), 16'h0001);
      brd(A_WD_COUNT, d);
      chk("watchdog", 16'(d), 16'h0000);
      chk("kick status", 16'(status), exp_st());
      brd(A_STATUS, d);
      chk("status reg", 16'(d), exp_sreg());
      repeat (300) begin
         fx = ($urandom_range(0, 9) == 0) ? 7'h7F : 7'($urandom_range(0, 7));
         if ($urandom_range(0, 3) == 0) bwr({1'b0, fx}, 8'($urandom_range(0, 2)));
         if ($urandom_range(0, 5) == 0) bwr(A_ACC, 8'($urandom));
         if ($urandom_range(0, 7) == 0) bwr(A_LATCH, 8'($urandom));
         ti = '{iex_op_e'($urandom_range(0, 7)), fx, 1'($urandom_range(0, 1))};
         exec(ti);
         chk_regs(fx);
      end
      results();
   end
endmodule

// file: logic/iex_core.sv
// The implementer's own choices: strobed register access and the placing of the registers.
module iex_core
   import iex_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic instr_valid,
   input iex_instr_s instr,
   output logic instr_ready,
   input iex_bus_s bus,
   output logic [DATA_W-1:0] rdata,
   output logic [PC_W-1:0] pc,
   output logic [PC_W-1:0] top_of_stack,
   output iex_status_s status
);

   iex_state_s q;
   iex_state_s next_q;

   logic accept;
   logic exec;
   logic [DATA_W-1:0] opnd;
   logic [DATA_W-1:0] dec_res;
   logic [DATA_W-1:0] inv_res;

   // ************************************************
   // Issue and operand path
   // ************************************************
   // The dead second cycle of a call stalls issue instead of buffering.
   assign instr_ready = (q.fsm == ST_RUN);
   assign accept = instr_valid && instr_ready;
   // A pending skip eats the next accepted instruction.
   assign exec = accept && !q.skip;
   assign opnd = q.fregs[instr.fidx];
   assign dec_res = opnd - BYTE_ONE;
   assign inv_res = ~opnd;

   assign rdata = q.rdata;
   assign pc = q.pc;
   assign top_of_stack = q.top_of_stack;
   assign status = q.status;

   // ************************************************
   // Next state
   // ************************************************
   always_comb begin
      next_q = q;
      next_q.rdata = RST_BYTE;
      // Free-running stand-in timebase, so a clear is observable.
      next_q.wd_prescale = q.wd_prescale + BYTE_ONE;
      if (q.wd_prescale == {DATA_W{1'b1}}) begin
         next_q.watchdog_counter = q.watchdog_counter + BYTE_ONE;
      end
      // Software writes go first so a same-cycle instruction wins.
      if (bus.wr) begin
         if (!bus.addr[ADDR_W-1]) begin
            next_q.fregs[bus.addr[FIDX_W-1:0]] = bus.wdata;
         end else if (bus.addr == A_ACC) begin
            next_q.acc = bus.wdata;
         end else if (bus.addr == A_LATCH) begin
            next_q.pc_upper_latch = bus.wdata[LATCH_W-1:0];
         end
      end
      if (bus.rd) begin
         if (!bus.addr[ADDR_W-1]) begin
            next_q.rdata = q.fregs[bus.addr[FIDX_W-1:0]];
         end else if (bus.addr == A_ACC) begin
            next_q.rdata = q.acc;
         end else if (bus.addr == A_LATCH) begin
            next_q.rdata = {1'b0, q.pc_upper_latch};
         end else if (bus.addr == A_STATUS) begin
            next_q.rdata[STAT_ZERO] = q.status.zero;
            next_q.rdata[STAT_EXPIRED_N] = q.status.watchdog_expired_n;
            next_q.rdata[STAT_SLEEP_N] = q.status.sleep_entered_n;
         end else if (bus.addr == A_PC_LO) begin
            next_q.rdata = q.pc[DATA_W-1:0];
         end else if (bus.addr == A_PC_HI) begin
            next_q.rdata = {1'b0, q.pc[PC_W-1:DATA_W]};
         end else if (bus.addr == A_STACK_LO) begin
            next_q.rdata = q.top_of_stack[DATA_W-1:0];
         end else if (bus.addr == A_STACK_HI) begin
            next_q.rdata = {1'b0, q.top_of_stack[PC_W-1:DATA_W]};
         end else if (bus.addr == A_WD_COUNT) begin
            next_q.rdata = q.watchdog_counter;
         end else if (bus.addr == A_PRE) begin
            next_q.rdata = q.wd_prescale;
         end
      end
      case (q.fsm)
         ST_CALL2: begin
            next_q.fsm = ST_RUN;
         end
         default: begin
            if (accept && q.skip) begin
               next_q.skip = 1'b0;
               next_q.pc = q.pc + PC_STEP;
            end else if (exec) begin
               next_q.pc = q.pc + PC_STEP;
               case (instr.op)
                  OP_CALL_VIA_ACCUMULATOR: begin
                     next_q.top_of_stack = q.pc + PC_STEP;
                     next_q.pc = {q.pc_upper_latch, q.acc};
                     next_q.fsm = ST_CALL2;
                  end
                  OP_ZERO_FILE_REG: begin
                     next_q.fregs[instr.fidx] = RST_BYTE;
                     next_q.status.zero = 1'b1;
                  end
                  OP_ZERO_ACCUMULATOR: begin
                     next_q.acc = RST_BYTE;
                     next_q.status.zero = 1'b1;
                  end
                  OP_KICK_WATCHDOG: begin
                     next_q.watchdog_counter = RST_BYTE;
                     next_q.wd_prescale = RST_BYTE;
                     next_q.status.watchdog_expired_n = 1'b1;
                     next_q.status.sleep_entered_n = 1'b1;
                  end
                  OP_INVERT_FILE_REG: begin
                     if (instr.dest) begin
                        next_q.fregs[instr.fidx] = inv_res;
                     end else begin
                        next_q.acc = inv_res;
                     end
                     next_q.status.zero = (inv_res == RST_BYTE);
                  end
                  OP_DECREMENT_FILE_REG: begin
                     if (instr.dest) begin
                        next_q.fregs[instr.fidx] = dec_res;
                     end else begin
                        next_q.acc = dec_res;
                     end
                     next_q.status.zero = (dec_res == RST_BYTE);
                  end
                  OP_DECREMENT_SKIP_ON_NULL: begin
                     if (instr.dest) begin
                        next_q.fregs[instr.fidx] = dec_res;
                     end else begin
                        next_q.acc = dec_res;
                     end
                     // Zero flag is deliberately untouched here.
                     next_q.skip = (dec_res == RST_BYTE);
                  end
                  default: begin
                  end
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q.fsm <= ST_RUN;
         q.fregs <= '0;
         q.acc <= RST_BYTE;
         q.pc <= RST_PC;
         q.top_of_stack <= RST_PC;
         q.pc_upper_latch <= '0;
         q.status.zero <= 1'b0;
         q.status.watchdog_expired_n <= RST_FLAG_N;
         q.status.sleep_entered_n <= RST_FLAG_N;
         q.watchdog_counter <= RST_BYTE;
         q.wd_prescale <= RST_BYTE;
         q.skip <= 1'b0;
         q.rdata <= RST_BYTE;
      end else begin
         q <= next_q;
      end
   end

   // ************************************************
   // Assertions
   // ************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   logic ex_call;
   logic ex_dsz;
   assign ex_call = exec && (instr.op == OP_CALL_VIA_ACCUMULATOR);
   assign ex_dsz = exec && (instr.op == OP_DECREMENT_SKIP_ON_NULL);
   logic ex_kick;
   assign ex_kick = exec && (instr.op == OP_KICK_WATCHDOG);

   property p_call_push;
      ex_call |=> q.top_of_stack == $past(q.pc) + PC_STEP;
   endproperty
   a_call_push: assert property (p_call_push)
      else $error("call return address wrong");

   property p_call_target;
      ex_call |=> q.pc == {$past(q.pc_upper_latch), $past(q.acc)};
   endproperty
   a_call_target: assert property (p_call_target)
      else $error("call target wrong");

   property p_call_two;
      ex_call |=> !instr_ready ##1 instr_ready && $stable(q.status);
   endproperty
   a_call_two: assert property (p_call_two)
      else $error("call not two cycles or flags changed");

   property p_zero_freg;
      exec && instr.op == OP_ZERO_FILE_REG
         |=> q.fregs[$past(instr.fidx)] == RST_BYTE && q.status.zero;
   endproperty
   a_zero_freg: assert property (p_zero_freg)
      else $error("file register clear failed");

   property p_zero_acc;
      exec && instr.op == OP_ZERO_ACCUMULATOR |=> q.acc == RST_BYTE && q.status.zero;
   endproperty
   a_zero_acc: assert property (p_zero_acc)
      else $error("accumulator clear failed");

   // A second kick right behind the first holds the prescaler at zero.
   property p_kick;
      ex_kick
         |=> q.watchdog_counter == RST_BYTE && q.wd_prescale == RST_BYTE
            ##1 (q.wd_prescale == BYTE_ONE || $past(ex_kick));
   endproperty
   a_kick: assert property (p_kick)
      else $error("watchdog not cleared");

   property p_kick_flags;
      exec && instr.op == OP_KICK_WATCHDOG
         |=> q.status.watchdog_expired_n && q.status.sleep_entered_n;
   endproperty
   a_kick_flags: assert property (p_kick_flags)
      else $error("watchdog status bits not set");

   property p_invert;
      exec && instr.op == OP_INVERT_FILE_REG
         |=> ($past(instr.dest) ? q.fregs[$past(instr.fidx)] : q.acc) == ~$past(opnd);
   endproperty
   a_invert: assert property (p_invert)
      else $error("complement result wrong");

   property p_decrement;
      exec && instr.op == OP_DECREMENT_FILE_REG
         |=> ($past(instr.dest) ? q.fregs[$past(instr.fidx)] : q.acc)
            == $past(opnd) - BYTE_ONE;
   endproperty
   a_decrement: assert property (p_decrement)
      else $error("decrement result wrong");

   property p_dsz_store;
      ex_dsz |=> ($past(instr.dest) ? q.fregs[$past(instr.fidx)] : q.acc)
         == $past(opnd) - BYTE_ONE && $stable(q.status.zero);
   endproperty
   a_dsz_store: assert property (p_dsz_store)
      else $error("decrement skip store wrong");

   property p_skip_nop;
      q.skip && accept && !bus.wr
         |=> !q.skip && $stable(q.acc) && $stable(q.fregs) && $stable(q.status)
            && q.pc == $past(q.pc) + PC_STEP;
   endproperty
   a_skip_nop: assert property (p_skip_nop)
      else $error("skipped instruction had an effect");

   property p_no_skip;
      ex_dsz && opnd != BYTE_ONE |=> !q.skip;
   endproperty
   a_no_skip: assert property (p_no_skip)
      else $error("skip armed on nonzero result");

   property p_zero_flag;
      exec && (instr.op == OP_INVERT_FILE_REG || instr.op == OP_DECREMENT_FILE_REG)
         |=> q.status.zero == (($past(instr.op) == OP_INVERT_FILE_REG ?
            ~$past(opnd) : $past(opnd) - BYTE_ONE) == RST_BYTE);
   endproperty
   a_zero_flag: assert property (p_zero_flag)
      else $error("zero flag wrong");

   property p_call_hold;
      q.fsm == ST_CALL2
         |=> $stable(q.pc) && $stable(q.top_of_stack) && $stable(q.status);
   endproperty
   a_call_hold: assert property (p_call_hold)
      else $error("dead call cycle changed state");

   property p_zero_freg_keep;
      exec && instr.op == OP_ZERO_FILE_REG && !bus.wr |=> $stable(q.acc);
   endproperty
   a_zero_freg_keep: assert property (p_zero_freg_keep)
      else $error("file register clear touched accumulator");

   property p_zero_acc_keep;
      exec && instr.op == OP_ZERO_ACCUMULATOR && !bus.wr |=> $stable(q.fregs);
   endproperty
   a_zero_acc_keep: assert property (p_zero_acc_keep)
      else $error("accumulator clear touched file registers");

   property p_invert_other;
      exec && instr.op == OP_INVERT_FILE_REG && !bus.wr
         |=> ($past(instr.dest) ? $stable(q.acc) : (q.fregs[$past(instr.fidx)] == $past(opnd)));
   endproperty
   a_invert_other: assert property (p_invert_other)
      else $error("complement wrote the wrong destination");

   property p_decrement_other;
      exec && instr.op == OP_DECREMENT_FILE_REG && !bus.wr
         |=> ($past(instr.dest) ? $stable(q.acc) : (q.fregs[$past(instr.fidx)] == $past(opnd)));
   endproperty
   a_decrement_other: assert property (p_decrement_other)
      else $error("decrement wrote the wrong destination");

   property p_dsz_other;
      ex_dsz && !bus.wr
         |=> ($past(instr.dest) ? $stable(q.acc) : (q.fregs[$past(instr.fidx)] == $past(opnd)));
   endproperty
   a_dsz_other: assert property (p_dsz_other)
      else $error("decrement skip wrote the wrong destination");

   property p_skip_arm;
      ex_dsz && opnd == BYTE_ONE |=> q.skip;
   endproperty
   a_skip_arm: assert property (p_skip_arm)
      else $error("skip not armed on zero result");

   property p_skip_hold;
      q.skip && !accept |=> q.skip;
   endproperty
   a_skip_hold: assert property (p_skip_hold)
      else $error("pending skip lost without an instruction");

   property p_pc_step;
      exec && instr.op != OP_CALL_VIA_ACCUMULATOR |=> q.pc == $past(q.pc) + PC_STEP;
   endproperty
   a_pc_step: assert property (p_pc_step)
      else $error("program counter did not step");

   c_call: cover property (ex_call ##2 instr_ready);
   c_skip: cover property (q.skip && accept);
   c_kick: cover property (exec && instr.op == OP_KICK_WATCHDOG);
   c_read: cover property (bus.rd && bus.addr == A_STATUS);

endmodule

// file: shared/iex_pkg.sv
// Contract
// - Call via accumulator pushes program counter plus one onto the stack top.
// - Call loads accumulator into pc[7:0] and upper latch [6:0] into pc[14:8].
// - Call via accumulator takes two cycles and leaves status flags alone.
// - Zero file reg clears the indexed register (0..127) and sets zero flag.
// - Zero accumulator clears the accumulator and sets the zero flag.
// - Kick watchdog clears the watchdog counter and its prescaler.
// - Kick watchdog sets the expired and sleep status bits to one.
// - Invert file reg complements f; destination bit picks accumulator or f.
// - Decrement file reg subtracts one; destination bit picks accumulator or f.
// - Decrement skip subtracts one and stores by the destination bit.
// - A zero decrement skip result turns the next instruction into a no-op.
// - A nonzero decrement skip result lets the next instruction run normally.
package iex_pkg;
   localparam int PC_W = 15;
   localparam int DATA_W = 8;
   localparam int FIDX_W = 7;
   localparam int LATCH_W = 7;
   localparam int ADDR_W = 8;
   localparam int NFREG = 128;

   // ************************************************
   // Register port map
   // ************************************************
   localparam logic [ADDR_W-1:0] A_ACC = 8'h80;
   localparam logic [ADDR_W-1:0] A_LATCH = 8'h81;
   localparam logic [ADDR_W-1:0] A_STATUS = 8'h82;
   localparam logic [ADDR_W-1:0] A_PC_LO = 8'h83;
   localparam logic [ADDR_W-1:0] A_PC_HI = 8'h84;
   localparam logic [ADDR_W-1:0] A_STACK_LO = 8'h85;
   localparam logic [ADDR_W-1:0] A_STACK_HI = 8'h86;
   localparam logic [ADDR_W-1:0] A_WD_COUNT = 8'h87;
   localparam logic [ADDR_W-1:0] A_PRE = 8'h88;
   localparam int STAT_ZERO = 2;
   localparam int STAT_EXPIRED_N = 4;
   localparam int STAT_SLEEP_N = 3;

   // ************************************************
   // Reset values and unit increments
   // ************************************************
   localparam logic [PC_W-1:0] RST_PC = 15'h0000;
   localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
   localparam logic RST_FLAG_N = 1'b1;
   localparam logic [PC_W-1:0] PC_STEP = 15'h0001;
   localparam logic [DATA_W-1:0] BYTE_ONE = 8'h01;

   typedef enum logic [2:0] {
      OP_NOP = 3'h0,
      OP_CALL_VIA_ACCUMULATOR = 3'h1,
      OP_ZERO_FILE_REG = 3'h2,
      OP_ZERO_ACCUMULATOR = 3'h3,
      OP_KICK_WATCHDOG = 3'h4,
      OP_INVERT_FILE_REG = 3'h5,
      OP_DECREMENT_FILE_REG = 3'h6,
      OP_DECREMENT_SKIP_ON_NULL = 3'h7
   } iex_op_e;

   typedef enum logic [0:0] {
      ST_RUN = 1'b0,
      ST_CALL2 = 1'b1
   } iex_fsm_e;

   typedef struct packed {
      iex_op_e op;
      logic [FIDX_W-1:0] fidx;
      logic dest;
   } iex_instr_s;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } iex_bus_s;

   typedef struct packed {
      logic zero;
      logic watchdog_expired_n;
      logic sleep_entered_n;
   } iex_status_s;

   typedef struct packed {
      iex_fsm_e fsm;
      logic [NFREG-1:0][DATA_W-1:0] fregs;
      logic [DATA_W-1:0] acc;
      logic [PC_W-1:0] pc;
      logic [PC_W-1:0] top_of_stack;
      logic [LATCH_W-1:0] pc_upper_latch;
      iex_status_s status;
      logic [DATA_W-1:0] watchdog_counter;
      logic [DATA_W-1:0] wd_prescale;
      logic skip;
      logic [DATA_W-1:0] rdata;
   } iex_state_s;
endpackage
